// ---- hdl/ext_mem_read_data_bus.sv ----
// External memory read strobe, shared upper data lines and register slave
`timescale 1ns/1ps
`include "ext_rd_bus_params.svh"
// What this block does
// - After reset the shared upper lines serve the data bus, not port F.
// - Clearing a port F pull-up bit disables that pin's pull-up, bit equals pin.
// - Strobe stays low through the read; all sixteen data lines are inputs then.
// - Read data is captured as the strobe returns high.
// - A low strobe qualifies address and space selects; they hold steady.
// - Strobe output floats when idle unless the drive-keep bit is set.
// - Setting the strobe pull-up control bit turns its pull-up off.
// - The top data line is port F pin 8 when used as GPIO.
module ext_mem_read_data_bus
  import ext_rd_bus_pkg::*;
#(
  parameter int RD_CYC = (`RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] ext_data_lines_in,
  output logic [15:0] ext_data_lines_out,
  output logic [15:0] ext_data_lines_oe,
  output ext_ctrl_t ext_ctrl,
  output logic [8:0] port_f_pullup_en,
  output logic strobe_pullup_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic [15:0] data_meta;
  logic [15:0] data_sync;

  always_ff @(posedge core_clk)
  begin
    data_meta <= ext_data_lines_in;
    data_sync <= data_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave
  logic bus_drive_keep;
  logic [8:0] port_f_gpio_en;
  logic [8:0] port_f_dir;
  logic [8:0] port_f_data;
  logic sys_pullup_disable;
  logic [17:0] rd_cmd;
  logic [15:0] rd_data;
  logic next_bus_drive_keep;
  logic [8:0] next_port_f_gpio_en;
  logic [8:0] next_port_f_dir;
  logic [8:0] next_port_f_data;
  logic [8:0] next_port_f_pullup_en;
  logic next_sys_pullup_disable;
  logic [17:0] next_rd_cmd;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic accept;
  logic do_write;
  logic start_rd;
  logic busy;
  logic [31:0] wmask;
  logic [31:0] wval;

  always_comb
  begin
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    wval = writedata & wmask;
    accept = (read || write) && waitrequest
      && !(write && address == `OFS_RD_CMD && busy);
    do_write = write && !waitrequest;
    start_rd = do_write && address == `OFS_RD_CMD;
    next_waitrequest = !accept;
    next_bus_drive_keep = bus_drive_keep;
    next_port_f_gpio_en = port_f_gpio_en;
    next_port_f_dir = port_f_dir;
    next_port_f_data = port_f_data;
    next_port_f_pullup_en = port_f_pullup_en;
    next_sys_pullup_disable = sys_pullup_disable;
    next_rd_cmd = rd_cmd;
    if (do_write)
    begin
      unique case (address)
        `OFS_BUS_CTRL:
          next_bus_drive_keep = byteenable[0] ? writedata[`BIT_DRIVE_KEEP] : bus_drive_keep;
        `OFS_F_GPIO_EN:
          next_port_f_gpio_en = (port_f_gpio_en & ~wmask[8:0]) | wval[8:0];
        `OFS_F_DIR:
          next_port_f_dir = (port_f_dir & ~wmask[8:0]) | wval[8:0];
        `OFS_F_DATA:
          next_port_f_data = (port_f_data & ~wmask[8:0]) | wval[8:0];
        `OFS_F_PULLUP:
          next_port_f_pullup_en = (port_f_pullup_en & ~wmask[8:0]) | wval[8:0];
        `OFS_SYS_PULLUP:
          next_sys_pullup_disable = byteenable[0] ? writedata[`BIT_STROBE_PUD]
                                                  : sys_pullup_disable;
        `OFS_RD_CMD:
          next_rd_cmd = (rd_cmd & ~wmask[17:0]) | wval[17:0];
        default:
          next_rd_cmd = rd_cmd;
      endcase
    end
    next_readdata = 32'h0000_0000;
    if (accept && read)
    begin
      unique case (address)
        `OFS_BUS_CTRL:
          next_readdata[`BIT_DRIVE_KEEP] = bus_drive_keep;
        `OFS_F_GPIO_EN:
          next_readdata[8:0] = port_f_gpio_en;
        `OFS_F_DIR:
          next_readdata[8:0] = port_f_dir;
        `OFS_F_DATA:
          next_readdata[8:0] = data_sync[15:`SHARED_LO];
        `OFS_F_PULLUP:
          next_readdata[8:0] = port_f_pullup_en;
        `OFS_SYS_PULLUP:
          next_readdata[`BIT_STROBE_PUD] = sys_pullup_disable;
        `OFS_RD_CMD:
          next_readdata[17:0] = rd_cmd;
        `OFS_RD_DATA:
          next_readdata = {15'h0000, busy, rd_data};
        default:
          next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      waitrequest <= 1'h1;
      readdata <= 32'h0000_0000;
      bus_drive_keep <= 1'h0;
      port_f_gpio_en <= `RST_F_GPIO_EN;
      port_f_dir <= `RST_F_DIR;
      port_f_data <= 9'h000;
      port_f_pullup_en <= `RST_F_PULLUP;
      sys_pullup_disable <= 1'h0;
      rd_cmd <= 18'h00000;
    end
    else
    begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      bus_drive_keep <= next_bus_drive_keep;
      port_f_gpio_en <= next_port_f_gpio_en;
      port_f_dir <= next_port_f_dir;
      port_f_data <= next_port_f_data;
      port_f_pullup_en <= next_port_f_pullup_en;
      sys_pullup_disable <= next_sys_pullup_disable;
      rd_cmd <= next_rd_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read cycle sequencer and pins
  rd_state_t state;
  rd_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [15:0] next_rd_data;
  ext_ctrl_t next_ext_ctrl;
  logic [15:0] next_data_oe;
  logic [15:0] next_data_out;
  logic next_strobe_pullup_en;

  assign busy = state != RD_IDLE;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_rd_data = rd_data;
    next_ext_ctrl = ext_ctrl;
    unique case (state)
      RD_IDLE:
        if (start_rd)
        begin
          next_state = RD_SETUP;
          next_ext_ctrl.addr = next_rd_cmd[16:0];
          next_ext_ctrl.prog_space_n = next_rd_cmd[`BIT_RD_SPACE];
          next_ext_ctrl.data_space_n = !next_rd_cmd[`BIT_RD_SPACE];
        end
      RD_SETUP:
      begin
        next_state = RD_STROBE;
        next_ext_ctrl.rd_n = 1'h0;
        next_cnt = 8'(RD_CYC - 1);
      end
      RD_STROBE:
        if (cnt == 8'h00)
        begin
          next_state = RD_HOLD;
          next_ext_ctrl.rd_n = 1'h1;
          next_rd_data = data_sync;
        end
        else
          next_cnt = cnt - 8'h01;
      RD_HOLD:
      begin
        next_state = RD_IDLE;
        next_ext_ctrl.prog_space_n = 1'h1;
        next_ext_ctrl.data_space_n = 1'h1;
      end
    endcase
    next_ext_ctrl.oe = bus_drive_keep || next_state != RD_IDLE;
    next_data_oe = 16'h0000;
    next_data_out = 16'h0000;
    if (next_state == RD_IDLE)
    begin
      next_data_oe[15:`SHARED_LO] = next_port_f_gpio_en & next_port_f_dir;
      next_data_out[15:`SHARED_LO] = next_port_f_data;
    end
    next_strobe_pullup_en = !next_sys_pullup_disable;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state <= RD_IDLE;
      cnt <= 8'h00;
      rd_data <= 16'h0000;
      ext_ctrl <= '{addr: 17'h00000, prog_space_n: 1'h1, data_space_n: 1'h1,
                    rd_n: 1'h1, oe: 1'h0};
      ext_data_lines_oe <= 16'h0000;
      ext_data_lines_out <= 16'h0000;
      strobe_pullup_en <= 1'h1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      rd_data <= next_rd_data;
      ext_ctrl <= next_ext_ctrl;
      ext_data_lines_oe <= next_data_oe;
      ext_data_lines_out <= next_data_out;
      strobe_pullup_en <= next_strobe_pullup_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] low_cnt;

  always_ff @(posedge core_clk)
  begin
    if (srst || ext_ctrl.rd_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_reset_bus_role: assert property ($past(srst) |-> port_f_gpio_en == 9'h000)
    else $error("Shared lines not in data bus role after reset");
  a_gpio_dir_only: assert property (
    (ext_data_lines_oe[15:`SHARED_LO] & ~(port_f_gpio_en & port_f_dir)) == 9'h000)
    else $error("Port F pin driven without gpio output setting");
  a_pullup_bit_map: assert property (
    (write && !waitrequest && address == `OFS_F_PULLUP && byteenable[1])
      |=> port_f_pullup_en[8] == $past(writedata[8]))
    else $error("Port F pull-up bit 8 does not follow write");
  a_strobe_inputs: assert property (!ext_ctrl.rd_n |-> ext_data_lines_oe == 16'h0000)
    else $error("Data lines driven while strobe low");
  a_strobe_width: assert property ($rose(ext_ctrl.rd_n) |-> low_cnt == 8'(RD_CYC))
    else $error("Strobe low width wrong");
  a_capture_edge: assert property ($rose(ext_ctrl.rd_n) |-> rd_data == $past(data_sync))
    else $error("Read data not captured at strobe rise");
  a_qualify_stable: assert property (
    (!ext_ctrl.rd_n && $past(!ext_ctrl.rd_n))
      |-> $stable(ext_ctrl.addr) && ext_ctrl.oe
        && (ext_ctrl.prog_space_n != ext_ctrl.data_space_n))
    else $error("Address or selects change under strobe");
  a_idle_float: assert property (ext_ctrl.oe |-> $past(bus_drive_keep) || busy)
    else $error("Strobe driven while idle without drive keep");
  a_strobe_pullup: assert property (
    (write && !waitrequest && address == `OFS_SYS_PULLUP && byteenable[0])
      |=> ##1 strobe_pullup_en == !$past(writedata[`BIT_STROBE_PUD], 2))
    else $error("Strobe pull-up does not follow control bit");
  a_top_line_gpio: assert property (ext_data_lines_oe[15] |-> port_f_gpio_en[8])
    else $error("Top data line driven without port F pin 8 enabled");
  a_reset_off: assert property (
    $past(srst) |-> !ext_ctrl.oe && ext_data_lines_oe == 16'h0000)
    else $error("Drivers enabled right after reset");

endmodule

// ---- hdl/ext_rd_bus_params.svh ----
// Register map, reset values and timing of the external read bus
`ifndef EXT_RD_BUS_PARAMS_SVH
`define EXT_RD_BUS_PARAMS_SVH
`define OFS_BUS_CTRL 6'h00
`define OFS_F_GPIO_EN 6'h04
`define OFS_F_DIR 6'h08
`define OFS_F_DATA 6'h0c
`define OFS_F_PULLUP 6'h10
`define OFS_SYS_PULLUP 6'h14
`define OFS_RD_CMD 6'h18
`define OFS_RD_DATA 6'h1c
`define BIT_DRIVE_KEEP 0
`define BIT_STROBE_PUD 0
`define BIT_RD_SPACE 17
`define BIT_RD_BUSY 16
`define RST_F_GPIO_EN 9'h000
`define RST_F_DIR 9'h000
`define RST_F_PULLUP 9'h1ff
`define SHARED_LO 7
`define CLK_PERIOD_NS 5
`define RD_LOW_NS 40
`endif

// ---- hdl/ext_rd_bus_pkg.sv ----
// Types shared by the external read bus block
package ext_rd_bus_pkg;
  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_SETUP = 4'h2,
    RD_STROBE = 4'h4,
    RD_HOLD = 4'h8
  } rd_state_t;
  typedef struct packed {
    logic [16:0] addr;
    logic prog_space_n;
    logic data_space_n;
    logic rd_n;
    logic oe;
  } ext_ctrl_t;
endpackage

// ---- sim/sram_model.sv ----
// Behavioural external static memory answering the read strobe
`timescale 1ns/1ps
module sram_model
  import ext_rd_bus_pkg::*;
(
  input wire logic core_clk,
  input wire logic [2:0] lag,
  input ext_ctrl_t ext_ctrl,
  output logic [15:0] mem_data,
  output logic mem_drive
);
  logic [2:0] low_cnt = 3'h0;
  ////////////////////////////////////////
  // Counts strobe-low cycles for a slow answer
  always @(posedge core_clk)
  begin
    if (ext_ctrl.rd_n || !ext_ctrl.oe)
      low_cnt <= 3'h0;
    else if (low_cnt != 3'h7)
      low_cnt <= low_cnt + 3'h1;
  end
  // Word only while strobe low and enabled
  assign mem_drive = ext_ctrl.oe && !ext_ctrl.rd_n && (low_cnt >= lag);
  assign mem_data = ext_ctrl.addr[15:0] ^ 16'h5a3c ^ (ext_ctrl.data_space_n ? 16'h0000 : 16'h0ff0);
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench: registers, port F pins and external reads
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module testbench
  import ext_rd_bus_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] ext_data_lines_in;
  logic [15:0] ext_data_lines_out;
  logic [15:0] ext_data_lines_oe;
  ext_ctrl_t ext_ctrl;
  logic [8:0] port_f_pullup_en;
  logic strobe_pullup_en;
  logic [15:0] mem_data;
  logic mem_drive;
  logic [2:0] lag = 3'h0;
  logic exp_ds = 1'b0;
  logic keep = 1'b0;
  logic [16:0] exp_addr = 17'h0;
  logic [15:0] exp_q[$];
  logic [31:0] q;
  logic [8:0] v;
  logic [8:0] dir;
  logic [5:0] offs[6] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h20};
  logic [31:0] rst_val[6] = '{32'h0, 32'h0, 32'h0, 32'h1ff, 32'h0, 32'h0};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int low_cnt = 0;
  ext_mem_read_data_bus u_ext_mem_read_data_bus (.core_clk, .srst, .address, .read, .write,
    .writedata, .byteenable(4'hf), .readdata, .waitrequest, .ext_data_lines_in,
    .ext_data_lines_out, .ext_data_lines_oe, .ext_ctrl, .port_f_pullup_en, .strobe_pullup_en);
  sram_model u_sram_model (.core_clk, .lag, .ext_ctrl, .mem_data, .mem_drive);
  // Pin levels: device, then memory, else pull-up
  assign ext_data_lines_in = (ext_data_lines_oe & ext_data_lines_out)
    | (~ext_data_lines_oe & (mem_drive ? mem_data : 16'hffff));
  ////////////////////////////////////////
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  // Strobe-low watcher
  always @(posedge core_clk)
  begin
    if (!srst && !ext_ctrl.rd_n)
    begin
      low_cnt++;
      `CHK(ext_data_lines_oe, 16'h0000)
      `CHK({ext_ctrl.oe, ext_ctrl.addr, ext_ctrl.prog_space_n, ext_ctrl.data_space_n}, {1'b1, exp_addr, exp_ds, !exp_ds})
    end
  end
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do
      @(posedge core_clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hd8786620));
    repeat (19) @(posedge core_clk);
    `CHK({ext_data_lines_oe, ext_ctrl.oe, ext_ctrl.rd_n, port_f_pullup_en, strobe_pullup_en}, {16'h0000, 1'b0, 1'b1, 9'h1ff, 1'b1})
    @(posedge core_clk);
    srst <= 1'b0;
    bus(1'b1, 6'h20, 32'hffffffff);
    foreach (offs[i])
    begin
      bus(1'b0, offs[i], 32'h0);
      `CHK(q, rst_val[i])
    end
    $display("Test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 9'h1fe : (i == 1) ? 9'h0ff : 9'($urandom);
      bus(1'b1, 6'h10, {23'h0, v});
      `CHK(port_f_pullup_en, v)
    end
    for (int b = 1; b >= 0; b--)
    begin
      bus(1'b1, 6'h14, 32'(b));
      `CHK(strobe_pullup_en, !b[0])
    end
    bus(1'b1, 6'h10, 32'h1ff);
    $display("Test pull-ups done");
    dir = 9'($urandom) | 9'h100;
    v = 9'($urandom);
    bus(1'b1, 6'h04, 32'h1ff);
    bus(1'b1, 6'h08, {23'h0, dir});
    bus(1'b1, 6'h0c, {23'h0, v});
    `CHK(ext_data_lines_oe, {dir, 7'h00})
    `CHK(ext_data_lines_out[15:7], v)
    repeat (3) @(posedge core_clk);
    bus(1'b0, 6'h0c, 32'h0);
    `CHK(q[8:0], (v & dir) | ~dir)
    $display("Test port F done");
    for (int i = 0; i < 4; i++)
    begin
      keep = 1'(i >> 1);
      lag <= 3'(3 * (i % 2));
      bus(1'b1, 6'h00, {31'h0, keep});
      exp_addr = 17'($urandom);
      exp_ds = 1'(i ^ (i >> 1));
      exp_q.push_back(exp_addr[15:0] ^ 16'h5a3c ^ (exp_ds ? 16'h0ff0 : 16'h0000));
      low_cnt = 0;
      bus(1'b1, 6'h18, {14'h0, exp_ds, exp_addr});
      do
        bus(1'b0, 6'h1c, 32'h0);
      while (q[16] !== 1'b0);
      `CHK(q[15:0], exp_q.pop_front())
      `CHK(low_cnt, 8)
      `CHK({ext_ctrl.oe, ext_ctrl.rd_n}, {keep, 1'b1})
    end
    $display("Test external reads done");
    complete_run();
  end
endmodule
